// ### gpio_expander.sv
// How it works
// - input-mode pin: both high-side and low-side drivers off.
// - output-mode pin: exactly one driver on, chosen by its latch bit.
// - start is data falling while clock high; begins a transaction.
// - address byte arrives msb first; last bit is read/write.
// - own address acknowledged by holding data low through ninth clock.
// - data changes only with clock low; else it is start or stop.
// - stop is data rising while clock high; ends the transaction.
// - each byte is eight bits plus acknowledge; any byte count.
// - sender releases data before acknowledge; acker holds it low.
// - device acks every received byte; master acks every read byte but the last.
// - on master not-acknowledge the device releases data for stop.
// - bus address is 010000 plus select pin: 0x20 or 0x21.
// - direction bit 1 means read, 0 means write.
// - first byte of a write is the command, kept in the pointer.
// - pointer values 0 to 7 pick one of the eight registers; higher values read zero.
// - reads keep using the stored pointer until a new command.
// - pin level registers show live pins; writes to them ignored.
// - latch reads return the flop; latch ignored for input pins.
// - invert bit 1 flips reported input level, 0 keeps it.
// - direction bit 1 makes an input, 0 makes an output.
// - reset: latches and directions all ones, invert masks zero.
// - multi-byte write alternates between the two registers of a pair.
// - multi-byte read alternates between the two registers of a pair.
// - reset pin low returns registers and serial machine to defaults.
// - input pin edge asserts interrupt; pin return, read or stop clear.
`timescale 1ns/10ps
module gpio_expander
    import gpio_expander_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic addr_sel_i,
    input wire logic [15:0] port_pin_i,
    output logic [15:0] port_pin_o,
    output logic [15:0] port_pin_oe_o,
    output logic [15:0] high_side_driver_o,
    output logic [15:0] low_side_driver_o,
    output logic int_n_o,
    output logic int_n_oe_o
);

    logic [18:0] raw_in;
    logic [18:0] synced;

    assign raw_in = {addr_sel_i, sda_i, scl_i, port_pin_i};

    gpio_sync2 #(
        .WIDTH(19)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(raw_in),
        .sync_o(synced)
    );

    wire [15:0] pins = synced[15:0];
    wire scl = synced[16];
    wire sda = synced[17];
    wire addr_sel = synced[18];

    serial_state_t state;
    logic scl_d;
    logic sda_d;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] pointer;
    logic cmd_phase;
    logic rw_bit;
    logic sda_drive;
    logic [7:0] rw_reg [0:RW_COUNT-1];
    logic [15:0] snap;
    // synchroniser resets to zero, so the first snapshot must wait for it
    logic [1:0] snap_wait;
    wire snap_load = (snap_wait == 2'h1);
    wire snap_ready = (snap_wait == 2'h0);

    // edge and condition detection on the sampled bus lines
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start_seen = scl & scl_d & sda_d & ~sda;
    wire stop_seen = scl & scl_d & ~sda_d & sda;
    wire byte_done = scl_fall & (bit_cnt == BITS_PER_BYTE);

    // address compare; the select pin is assumed steady per transaction
    wire addr_hit = (shift[7:1] == {BUS_ADDR_UPPER, addr_sel});

    wire [15:0] latch_all = {rw_reg[1], rw_reg[0]};
    wire [15:0] invert_all = {rw_reg[3], rw_reg[2]};
    wire [15:0] dir_all = {rw_reg[5], rw_reg[4]};

    // reported levels follow pins in either direction; invert on inputs
    wire [15:0] level_all = pins ^ (invert_all & dir_all);

    wire ptr_valid = (pointer <= REG_LAST);
    wire ptr_writable = ptr_valid & (pointer[2:0] >= RW_BASE);
    wire [2:0] rw_idx = 3'(pointer[2:0] - RW_BASE);
    wire ptr_is_level = ptr_valid & (pointer[2:1] == 2'b00);
    wire [7:0] next_pointer = ptr_valid ? {pointer[7:1], ~pointer[0]}
                                        : pointer;

    function automatic logic [7:0] read_byte(input logic [7:0] ptr);
        logic [2:0] idx;
        idx = 3'(ptr[2:0] - RW_BASE);
        if (ptr > REG_LAST) begin
            read_byte = 8'h00;
        end else if (ptr[2:1] == 2'b00) begin
            read_byte = ptr[0] ? level_all[15:8] : level_all[7:0];
        end else begin
            read_byte = rw_reg[idx];
        end
    endfunction : read_byte

    wire [7:0] rd_data = read_byte(pointer);

    // a change on any input-mode pin against the last cleared snapshot
    wire int_pending = |((pins ^ snap) & dir_all);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    // serial slave machine; reset pin puts it back to idle
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            pointer <= POINTER_RESET;
            cmd_phase <= 1'b0;
            rw_bit <= 1'b0;
            sda_drive <= 1'b0;
            snap <= 16'h0000;
            snap_wait <= SNAP_WAIT_RESET;
            for (int i = 0; i < RW_COUNT; i++) begin
                rw_reg[i] <= RW_RESET[i];
            end
        end else begin
            if (!snap_ready) begin
                snap_wait <= 2'(snap_wait - 2'h1);
            end
            if (snap_load) begin
                snap <= pins;
            end
            if (start_seen) begin
                // repeated start also lands here and keeps the pointer
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_drive <= 1'b0;
            end else if (stop_seen) begin
                state <= ST_IDLE;
                sda_drive <= 1'b0;
                snap <= pins;
            end else begin
                case (state)
                    ST_IDLE: begin
                        sda_drive <= 1'b0;
                    end
                    ST_ADDR, ST_WRITE: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda};
                            bit_cnt <= 4'(bit_cnt + 4'h1);
                        end else if (byte_done) begin
                            if (state == ST_ADDR) begin
                                if (addr_hit) begin
                                    sda_drive <= 1'b1;
                                    rw_bit <= shift[0];
                                    state <= ST_ADDR_ACK;
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end else begin
                                sda_drive <= 1'b1;
                                state <= ST_WRITE_ACK;
                                if (cmd_phase) begin
                                    pointer <= shift;
                                    cmd_phase <= 1'b0;
                                end else begin
                                    if (ptr_writable) begin
                                        rw_reg[rw_idx] <= shift;
                                    end
                                    pointer <= next_pointer;
                                end
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (rw_bit) begin
                                shift <= rd_data;
                                sda_drive <= ~rd_data[7];
                                state <= ST_READ;
                            end else begin
                                sda_drive <= 1'b0;
                                cmd_phase <= 1'b1;
                                state <= ST_WRITE;
                            end
                        end
                    end
                    ST_WRITE_ACK: begin
                        if (scl_fall) begin
                            sda_drive <= 1'b0;
                            bit_cnt <= 4'h0;
                            state <= ST_WRITE;
                        end
                    end
                    ST_READ: begin
                        if (scl_rise) begin
                            bit_cnt <= 4'(bit_cnt + 4'h1);
                        end else if (byte_done) begin
                            sda_drive <= 1'b0;
                            state <= ST_READ_ACK;
                        end else if (scl_fall) begin
                            shift <= {shift[6:0], 1'b0};
                            sda_drive <= ~shift[6];
                        end
                    end
                    ST_READ_ACK: begin
                        if (scl_rise) begin
                            // a port read clears its interrupt, ack or not
                            if (ptr_is_level) begin
                                if (pointer[0]) begin
                                    snap[15:8] <= pins[15:8];
                                end else begin
                                    snap[7:0] <= pins[7:0];
                                end
                            end
                            if (sda) begin
                                state <= ST_IDLE;
                            end else begin
                                pointer <= next_pointer;
                            end
                        end else if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            shift <= rd_data;
                            sda_drive <= ~rd_data[7];
                            state <= ST_READ;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // port drivers; input mode turns both transistors off
    wire [15:0] drive_en = ~dir_all;
    wire [15:0] next_high = latch_all & drive_en;
    wire [15:0] next_low = ~latch_all & drive_en;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            port_pin_o <= 16'hFFFF;
            port_pin_oe_o <= 16'h0000;
            high_side_driver_o <= 16'h0000;
            low_side_driver_o <= 16'h0000;
        end else begin
            port_pin_o <= latch_all;
            port_pin_oe_o <= drive_en;
            high_side_driver_o <= next_high;
            low_side_driver_o <= next_low;
        end
    end

    // open-drain lines: the level is always low, only the enable moves
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            int_n_o <= 1'b0;
            int_n_oe_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            sda_oe_o <= sda_drive;
            int_n_o <= 1'b0;
            int_n_oe_o <= int_pending & snap_ready;
        end
    end

endmodule : gpio_expander

// ### gpio_expander_pkg.sv
package gpio_expander_pkg;

    // command pointer codes, one per byte register
    localparam logic [7:0] REG_PORT0_PIN_LEVELS = 8'h00;
    localparam logic [7:0] REG_PORT1_PIN_LEVELS = 8'h01;
    localparam logic [7:0] REG_PORT0_DRIVE_LATCH = 8'h02;
    localparam logic [7:0] REG_PORT1_DRIVE_LATCH = 8'h03;
    localparam logic [7:0] REG_PORT0_INVERT_MASK = 8'h04;
    localparam logic [7:0] REG_PORT1_INVERT_MASK = 8'h05;
    localparam logic [7:0] REG_PORT0_DIRECTION = 8'h06;
    localparam logic [7:0] REG_PORT1_DIRECTION = 8'h07;
    localparam logic [7:0] REG_LAST = 8'h07;

    // pointer code of the first writable register, which is index 0 in the flop array
    localparam logic [2:0] RW_BASE = 3'h2;
    localparam int RW_COUNT = 6;

    localparam logic [7:0] DRIVE_LATCH_RESET = 8'hFF;
    localparam logic [7:0] INVERT_MASK_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'hFF;
    localparam logic [7:0] RW_RESET [0:5] = '{
        DRIVE_LATCH_RESET, DRIVE_LATCH_RESET,
        INVERT_MASK_RESET, INVERT_MASK_RESET,
        DIRECTION_RESET, DIRECTION_RESET
    };
    localparam logic [7:0] POINTER_RESET = 8'h00;
    // edges after reset before the synchronised pins are real
    localparam logic [1:0] SNAP_WAIT_RESET = 2'h3;

    // 7-bit bus address: fixed upper bits, select pin as lowest bit
    localparam logic [5:0] BUS_ADDR_UPPER = 6'h10;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int SYNC_STAGES = 2;
    localparam int PORT_WIDTH = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_WRITE = 3'h2,
        ST_WRITE_ACK = 3'h6,
        ST_READ = 3'h7,
        ST_READ_ACK = 3'h5
    } serial_state_t;

endpackage : gpio_expander_pkg

// ### gpio_sync2.sv
`timescale 1ns/10ps
module gpio_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    // first stage is read by the second stage only
    logic [WIDTH-1:0] meta;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule : gpio_sync2

// ### gpio_expander_monitor.sv
`timescale 1ns/10ps
module gpio_expander_monitor (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_oe_o,
    input wire logic [15:0] port_pin_o,
    input wire logic [15:0] port_pin_oe_o,
    input wire logic [15:0] high_side_driver_o,
    input wire logic [15:0] low_side_driver_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_off;
        ((high_side_driver_o | low_side_driver_o) & ~port_pin_oe_o) == 0;
    endproperty
    a_off: assert property (p_off) else $error("input pin driven");
    property p_one;
        (high_side_driver_o & low_side_driver_o) == 0 &&
        (high_side_driver_o | low_side_driver_o) == port_pin_oe_o;
    endproperty
    a_one: assert property (p_one) else $error("not one driver");
    property p_lvl;
        high_side_driver_o == (port_pin_oe_o & port_pin_o);
    endproperty
    a_lvl: assert property (p_lvl) else $error("wrong level");
    property p_rst;
        $rose(reset_n_i) |-> port_pin_oe_o == 16'h0000 &&
            port_pin_o == 16'hFFFF && !sda_oe_o;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset");
    property p_chg;
        $changed(sda_oe_o) |-> !scl_i;
    endproperty
    a_chg: assert property (p_chg) else $error("data moved, clk high");
    property p_hold;
        sda_oe_o && $rose(scl_i) |=> sda_oe_o [*3];
    endproperty
    a_hold: assert property (p_hold) else $error("low not held");
    property p_stop;
        scl_i && $rose(sda_i) |=> !sda_oe_o [*4];
    endproperty
    a_stop: assert property (p_stop) else $error("drive after stop");
    property p_start;
        scl_i && $fell(sda_i) |=> !sda_oe_o [*8];
    endproperty
    a_start: assert property (p_start) else $error("drive in addr");
endmodule : gpio_expander_monitor
bind gpio_expander gpio_expander_monitor mon_u (.ref_clk_i, .reset_n_i,
    .scl_i, .sda_i, .sda_oe_o, .port_pin_o, .port_pin_oe_o,
    .high_side_driver_o, .low_side_driver_o);

// ### i2c_master_model.sv
`timescale 1ns/10ps
module i2c_master_model (
    input wire logic ref_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // clock stands high outside frames
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : tick
    // data set with clock low, read at mid high
    // long low half: the device moves data four clocks after scl falls
    task automatic bit_x(input logic b, output logic r);
        sda_low_o <= !b;
        tick(3);
        scl_o <= 1'b1;
        tick(2);
        r = sda_i;
        tick(1);
        scl_o <= 1'b0;
        tick(2);
    endtask : bit_x
    // also serves as repeated start
    task automatic start_c;
        sda_low_o <= 1'b0;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        sda_low_o <= 1'b1;
        tick(4);
        scl_o <= 1'b0;
        tick(2);
    endtask : start_c
    task automatic stop_c;
        sda_low_o <= 1'b1;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        sda_low_o <= 1'b0;
        tick(4);
    endtask : stop_c
    task automatic byte_x(input logic [7:0] tx, input logic ack_in,
                          output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], r);
            rx[i] = r;
        end
        bit_x(ack_in, ack);
    endtask : byte_x
endmodule : i2c_master_model

// ### gpio_expander_bench.sv
`timescale 1ns/10ps
module gpio_expander_bench
    import gpio_expander_pkg::*;
();
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic addr_sel = 1'b0;
    logic [15:0] ext_pins = 16'h0000;
    int bad_count = 0;
    int n_tests = 0;
    wire scl, sda_low, sda_o, sda_oe;
    wire [15:0] pin_o, pin_oe, hi_drv, lo_drv;
    wire int_n, int_oe;
    // open drain with pull-up
    wire sda = !(sda_low || (sda_oe && !sda_o));
    wire [15:0] pins = (pin_oe & pin_o) | (~pin_oe & ext_pins);
    always #25 ref_clk = !ref_clk;
    i2c_master_model m_u (.ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl),
        .sda_low_o(sda_low));
    gpio_expander dut_u (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .addr_sel_i(addr_sel), .port_pin_i(pins), .port_pin_o(pin_o),
        .port_pin_oe_o(pin_oe), .high_side_driver_o(hi_drv),
        .low_side_driver_o(lo_drv), .int_n_o(int_n), .int_n_oe_o(int_oe));
    task automatic chk(input string name, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic wr2(input logic [7:0] ptr, d0, d1);
        logic [7:0] rx;
        logic [2:0] a;
        logic ac;
        m_u.start_c();
        m_u.byte_x({BUS_ADDR_UPPER, addr_sel, 1'b0}, 1'b1, rx, ac);
        m_u.byte_x(ptr, 1'b1, rx, a[2]);
        m_u.byte_x(d0, 1'b1, rx, a[1]);
        m_u.byte_x(d1, 1'b1, rx, a[0]);
        m_u.stop_c();
        chk("wr acks", {ac, a}, 4'h0);
    endtask : wr2
    // first byte in high half of exp, partner byte in low half
    task automatic rd_chk(input string name, input logic [7:0] ptr,
                          input logic [15:0] exp);
        logic [7:0] x, y, rx;
        logic [2:0] a;
        logic s;
        m_u.start_c();
        m_u.byte_x({BUS_ADDR_UPPER, addr_sel, 1'b0}, 1'b1, rx, a[2]);
        m_u.byte_x(ptr, 1'b1, rx, a[1]);
        m_u.start_c();
        m_u.byte_x({BUS_ADDR_UPPER, addr_sel, 1'b1}, 1'b1, rx, a[0]);
        m_u.byte_x(8'hFF, 1'b0, x, s);
        m_u.byte_x(8'hFF, 1'b1, y, s);
        m_u.stop_c();
        chk("rd acks", a, 3'h0);
        chk(name, {x, y}, exp);
    endtask : rd_chk
    task automatic t_reset_vals;
        chk("oe", pin_oe, 16'h0000);
        chk("drv", hi_drv | lo_drv, 16'h0000);
        rd_chk("latch", REG_PORT0_DRIVE_LATCH, 16'hFFFF);
        rd_chk("invert", REG_PORT1_INVERT_MASK, 16'h0000);
        rd_chk("dir", REG_PORT0_DIRECTION, 16'hFFFF);
        $display("t_reset_vals done");
    endtask : t_reset_vals
    task automatic t_outputs;
        ext_pins <= 16'h3C96;
        wr2(REG_PORT0_DIRECTION, 8'h00, 8'h0F);
        wr2(REG_PORT1_DRIVE_LATCH, 8'h5A, 8'hA5);
        chk("oe", pin_oe, 16'hF0FF);
        chk("hi", hi_drv, 16'h50A5);
        chk("lo", lo_drv, 16'hA05A);
        rd_chk("latch", REG_PORT0_DRIVE_LATCH, 16'hA55A);
        $display("t_outputs done");
    endtask : t_outputs
    task automatic t_inputs;
        rd_chk("levels", REG_PORT0_PIN_LEVELS, 16'hA55C);
        wr2(REG_PORT0_PIN_LEVELS, 8'h12, 8'h34);
        wr2(REG_PORT0_INVERT_MASK, 8'hFF, 8'hFF);
        rd_chk("inverted", REG_PORT0_PIN_LEVELS, 16'hA553);
        wr2(8'h08, 8'h77, 8'h77);
        rd_chk("dir kept", REG_PORT0_DIRECTION, 16'h000F);
        rd_chk("void", 8'h08, 16'h0000);
        $display("t_inputs done");
    endtask : t_inputs
    // port b low nibble is input here, port a bit 0 an output
    task automatic t_interrupt;
        ext_pins <= 16'h3D96;
        m_u.tick(4);
        chk("int set", int_oe, 1'b1);
        chk("int lvl", int_n, 1'b0);
        ext_pins <= 16'h3C96;
        m_u.tick(4);
        chk("int back", int_oe, 1'b0);
        ext_pins <= 16'h3C97;
        m_u.tick(4);
        chk("int out pin", int_oe, 1'b0);
        ext_pins <= 16'h3D97;
        m_u.tick(4);
        chk("int again", int_oe, 1'b1);
        wr2(REG_PORT0_INVERT_MASK, 8'hFF, 8'hFF);
        m_u.tick(2);
        chk("int stop", int_oe, 1'b0);
        $display("t_interrupt done");
    endtask : t_interrupt
    task automatic t_address;
        logic [7:0] rx;
        logic ac;
        addr_sel <= 1'b1; // held for whole frame
        m_u.tick(4);
        m_u.start_c();
        m_u.byte_x({BUS_ADDR_UPPER, 1'b0, 1'b0}, 1'b1, rx, ac);
        m_u.stop_c();
        chk("foreign", ac, 1'b1);
        rd_chk("sel high", REG_PORT1_DIRECTION, 16'h0F00);
        $display("t_address done");
    endtask : t_address
    task automatic t_mid_reset;
        reset_n <= 1'b0;
        m_u.tick(3);
        reset_n <= 1'b1;
        m_u.tick(6);
        chk("oe", pin_oe, 16'h0000);
        chk("int", int_oe, 1'b0);
        rd_chk("dir", REG_PORT0_DIRECTION, 16'hFFFF);
        $display("t_mid_reset done");
    endtask : t_mid_reset
    initial begin
        m_u.tick(3);
        reset_n <= 1'b1;
        m_u.tick(4);
        t_reset_vals();
        t_outputs();
        t_inputs();
        t_interrupt();
        t_address();
        t_mid_reset();
        stop_test();
    end
    // hang guard
    initial begin
        m_u.tick(60000);
        bad_count++;
        stop_test();
    end
endmodule : gpio_expander_bench
